// ==== include/ssm_pkg.sv ====
/*
 * Package for the supply supervisor mode controller: register offsets,
 * field positions, reset values, unit states and settling times.
 * Assumes a 200 MHz system clock and a word-addressed Avalon-MM slave.
 */
// Notes on behaviour
// RL1 - Low-side units in normal mode mask execution 150 us after deep sleep three/four.
// RL2 - Both low-side units off or both full: the wakeup mask lasts only 2 us.
// RL3 - Sub clock from the digital oscillator is never gated on deep-sleep exit.
// RL4 - Software divides main clock by two before sleep, waits cycles before undoing.
// RL5 - Software waits cycles by core level before re-enabling sub-clock modules.
// RL6 - Low-side supervisor full performance gives about 2 us comparator settling.
// RL7 - Low-side supervisor normal mode gives about 150 us comparator settling.
// RL8 - Raising core level with early expiry resets; software picks normal mode first.
// RL9 - Software waits for both delay flags clear before deep sleep two to four.
// RL10 - Low-side supervisor state follows enable, performance, keep-in-sleep and auto control.
// RL11 - Low-side monitor off if disabled; automatic deep sleep steps state down once.
// RL12 - High-side supervisor state follows enable, performance, keep-in-sleep and auto control.
// RL13 - High-side monitor off if disabled; automatic deep sleep steps state down once.
// RL14 - Fast wakeup when low-side supervisor off or full; slow when enabled normal.
// RL15 - Normal low-side supervisor makes deep sleep two to four wakeup slow, 150 us.
// RL16 - Software may add 150 us delay for fast interrupt servicing.
// RL17 - Writing a supervisor control register sets its delay flag until settling elapses.
`default_nettype none

package ssm_pkg;
    // ========================================
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int T_SLOW_US        = 150;
    localparam int T_FAST_US        = 2;
    localparam int SLOW_CYCLES      = T_SLOW_US * CLK_MHZ;
    localparam int FAST_CYCLES      = T_FAST_US * CLK_MHZ;
    localparam int CNT_W            = 16;
    // ========================================
    // Register offsets (word index)
    localparam logic [3:0] OFS_LOW_CTL   = 4'h0;
    localparam logic [3:0] OFS_HIGH_CTL  = 4'h1;
    localparam logic [3:0] OFS_MODE      = 4'h2;
    localparam logic [3:0] OFS_STATUS    = 4'h3;
    localparam logic [3:0] OFS_IRQ_FLAG  = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK  = 4'h5;
    // ========================================
    // Control fields (same layout both sides)
    localparam int F_SUP_EN     = 0;
    localparam int F_SUP_KEEP   = 1;
    localparam int F_SUP_FULL   = 2;
    localparam int F_MON_EN     = 3;
    localparam int F_MON_FULL   = 4;
    localparam int F_AUTO       = 5;
    localparam int CTL_W        = 6;
    // Mode register fields
    localparam int F_PWR_LO     = 0;
    localparam int F_SUB_DCO    = 2;
    // Interrupt bits
    localparam int I_LOW_DONE   = 0;
    localparam int I_HIGH_DONE  = 1;
    localparam int I_WAKE_DONE  = 2;
    localparam int IRQ_W        = 3;
    // ========================================
    // Reset values
    localparam logic [CTL_W-1:0] LOW_CTL_RST  = 6'h0_9;
    localparam logic [CTL_W-1:0] HIGH_CTL_RST = 6'h0_9;
    localparam logic [2:0]       MODE_RST     = 3'h0;
    // ========================================
    // Power modes and unit states
    typedef enum logic [1:0] {PM_ACTIVE, PM_LIGHT, PM_DEEP2, PM_DEEP34} ssm_pmode_type;
    typedef enum logic [1:0] {US_OFF, US_NORMAL, US_FULL} ssm_unit_type;
endpackage

`default_nettype wire

// ==== design/ssm_unit_state.sv ====
/*
 * Works out one side's supervisor and monitor states from its control bits and
 * the power mode. Purely combinational; the caller registers the result.
 */
`default_nettype none

module ssm_unit_state
    import ssm_pkg::*;
(
    input  wire logic [CTL_W-1:0] ctl,
    input  wire logic             deep,
    output logic [1:0]            sup_st,
    output logic [1:0]            mon_st
);
    // ========================================
    // Supervisor
    wire sup_base_full = ctl[F_SUP_FULL];
    wire [1:0] sup_awake = ctl[F_SUP_EN] ? (sup_base_full ? US_FULL : US_NORMAL) : US_OFF;
    wire [1:0] sup_man   = ctl[F_SUP_KEEP] ? sup_awake : US_OFF;
    wire [1:0] sup_auto  = (ctl[F_SUP_EN] && ctl[F_SUP_KEEP] && sup_base_full) ? US_NORMAL : US_OFF;
    assign sup_st = !deep ? sup_awake : (ctl[F_AUTO] ? sup_auto : sup_man);  // see RL10 see RL12
    // ========================================
    // Monitor: automatic deep sleep steps down by one
    wire [1:0] mon_awake = ctl[F_MON_EN] ? (ctl[F_MON_FULL] ? US_FULL : US_NORMAL) : US_OFF;
    wire [1:0] mon_auto  = (mon_awake == US_FULL) ? US_NORMAL : US_OFF;
    assign mon_st = (deep && ctl[F_AUTO]) ? mon_auto : mon_awake;  // see RL11 see RL13
endmodule // ssm_unit_state

`default_nettype wire

// ==== design/ssm_delay_timer.sv ====
/*
 * Settling delay down-counter with a busy flag. A start pulse loads the
 * count; busy falls when it reaches zero. Same clock as its caller.
 */
`default_nettype none

module ssm_delay_timer
    import ssm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load,
    output logic                  busy,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_reg;
    logic             busy_reg;
    logic             done_reg;
    wire              last = busy_reg && (cnt_reg == CNT_W'(1));

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= last && !start;
            if (start) begin
                cnt_reg  <= load;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg  <= cnt_reg - CNT_W'(1);
                busy_reg <= !last;
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule // ssm_delay_timer

`default_nettype wire

// ==== design/ssm_supervisor_mode_ctrl.sv ====
/*
 * Supply supervisor mode controller: control registers over Avalon-MM,
 * unit states per power mode, settling delays with delay flags, wakeup
 * execution mask and sub clock gating. Assumes the power mode and a
 * wakeup pulse come from power logic on the same clock.
 */
`default_nettype none

module ssm_supervisor_mode_ctrl
    import ssm_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [1:0]  POWER_MODE,
    input  wire logic        WAKE_EVENT,
    output logic [1:0]       LOW_SUP_STATE,
    output logic [1:0]       LOW_MON_STATE,
    output logic [1:0]       HIGH_SUP_STATE,
    output logic [1:0]       HIGH_MON_STATE,
    output logic             SLOW_WAKEUP,
    output logic             EXEC_MASK,
    output logic             SUB_CLK_GATE,
    output logic             IRQ
);
    // ========================================
    // Registers
    logic [CTL_W-1:0] low_ctl_reg;
    logic [CTL_W-1:0] high_ctl_reg;
    logic [2:0]       mode_reg;
    logic [IRQ_W-1:0] flag_reg;
    logic [IRQ_W-1:0] flag_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [31:0]      rdata_reg;
    logic             ack_reg;
    logic             wait_reg;
    logic [1:0]       pm_s_reg;
    logic             wake_s_reg;
    logic [1:0]       lo_sup_reg;
    logic [1:0]       lo_mon_reg;
    logic [1:0]       hi_sup_reg;
    logic [1:0]       hi_mon_reg;
    logic             slow_reg;
    logic             mask_out_reg;
    logic             gate_reg;
    logic             irq_reg;

    // ========================================
    // Bus decode: one wait cycle per access
    wire req      = (AVS_READ || AVS_WRITE) && !ack_reg;
    wire wr       = AVS_WRITE && ack_reg;
    wire rd       = AVS_READ && ack_reg;
    wire wr_low   = wr && (AVS_ADDRESS == OFS_LOW_CTL);
    wire wr_high  = wr && (AVS_ADDRESS == OFS_HIGH_CTL);
    wire wr_mode  = wr && (AVS_ADDRESS == OFS_MODE);
    wire wr_mask  = wr && (AVS_ADDRESS == OFS_IRQ_MASK);
    wire rd_flag  = rd && (AVS_ADDRESS == OFS_IRQ_FLAG);
    wire [CTL_W-1:0] wr_ctl = AVS_WRITEDATA[CTL_W-1:0];
    // Raising the core level reruns the low-side settling delay
    wire core_raise = wr_mode && (AVS_WRITEDATA[1:0] > mode_reg[1:0]);     // see RL8

    // ========================================
    // Unit states
    wire deep = (pm_s_reg == PM_DEEP2) || (pm_s_reg == PM_DEEP34);
    wire [1:0] lo_sup_w;
    wire [1:0] lo_mon_w;
    wire [1:0] hi_sup_w;
    wire [1:0] hi_mon_w;

    ssm_unit_state u_low (
        .ctl    (low_ctl_reg),
        .deep   (deep),
        .sup_st (lo_sup_w),
        .mon_st (lo_mon_w)
    );

    ssm_unit_state u_high (
        .ctl    (high_ctl_reg),
        .deep   (deep),
        .sup_st (hi_sup_w),
        .mon_st (hi_mon_w)
    );

    // ========================================
    // Settling and wakeup timing
    wire lo_sup_normal = low_ctl_reg[F_SUP_EN] && !low_ctl_reg[F_SUP_FULL];
    wire lo_mon_normal = low_ctl_reg[F_MON_EN] && !low_ctl_reg[F_MON_FULL];
    wire lo_fast_both  = (!low_ctl_reg[F_SUP_EN] && !low_ctl_reg[F_MON_EN])
                      || (low_ctl_reg[F_SUP_FULL] && low_ctl_reg[F_MON_FULL]);
    wire slow_w        = lo_sup_normal;                                     // see RL14 see RL15
    // Normal supervisor settles slowly, full quickly
    function automatic logic [CNT_W-1:0] settle_len(input logic [CTL_W-1:0] c);
        return (c[F_SUP_EN] && !c[F_SUP_FULL]) ? CNT_W'(SLOW_CYCLES) : CNT_W'(FAST_CYCLES);
    endfunction
    // Length follows the value being written, not the one it replaces
    wire [CNT_W-1:0] lo_settle = settle_len(wr_low ? wr_ctl : low_ctl_reg); // see RL6 see RL7
    wire [CNT_W-1:0] hi_settle = settle_len(wr_ctl);
    wire             lo_start  = wr_low || core_raise;                      // see RL8
    // Mixed configuration keeps the long mask; only the two pure cases shorten it
    wire [CNT_W-1:0] wake_len = lo_fast_both ? CNT_W'(FAST_CYCLES) : CNT_W'(SLOW_CYCLES);     // see RL1 see RL2
    wire wake34 = wake_s_reg && (pm_s_reg == PM_DEEP34);
    // Every deep three/four wake is masked; only the length differs
    wire wake_start = wake34;

    wire lo_busy;
    wire hi_busy;
    wire wk_busy;
    wire lo_done;
    wire hi_done;
    wire wk_done;

    ssm_delay_timer u_lo_dly (
        .clk   (CLK),
        .srst  (SRST),
        .start (lo_start),        // see RL17
        .load  (lo_settle),
        .busy  (lo_busy),
        .done  (lo_done)
    );

    ssm_delay_timer u_hi_dly (
        .clk   (CLK),
        .srst  (SRST),
        .start (wr_high),         // see RL17
        .load  (hi_settle),
        .busy  (hi_busy),
        .done  (hi_done)
    );

    ssm_delay_timer u_wk_dly (
        .clk   (CLK),
        .srst  (SRST),
        .start (wake_start),
        .load  (wake_len),
        .busy  (wk_busy),
        .done  (wk_done)
    );

    // Sub clock from the oscillator is never masked on wakeup
    wire gate_w = wk_busy && !mode_reg[F_SUB_DCO];                         // see RL3

    // ========================================
    // Interrupt flags: set wins over read-clear
    wire [IRQ_W-1:0] ev = {wk_done, hi_done, lo_done};
    // Clear only the bits the read returned, so a late event is not lost
    assign flag_next = (flag_reg & ~(rd_flag ? rdata_reg[IRQ_W-1:0] : '0)) | ev;

    wire [31:0] rd_mux =
        (AVS_ADDRESS == OFS_LOW_CTL)  ? {26'h0, low_ctl_reg} :
        (AVS_ADDRESS == OFS_HIGH_CTL) ? {26'h0, high_ctl_reg} :
        (AVS_ADDRESS == OFS_MODE)     ? {29'h0, mode_reg} :
        (AVS_ADDRESS == OFS_STATUS)   ? {20'h0, wk_busy, slow_reg, lo_sup_reg, lo_mon_reg,
                                         hi_sup_reg, hi_mon_reg, hi_busy, lo_busy} :
        (AVS_ADDRESS == OFS_IRQ_FLAG) ? {29'h0, flag_reg} :
        (AVS_ADDRESS == OFS_IRQ_MASK) ? {29'h0, mask_reg} : 32'h0000_0000;

    // ========================================
    // Sequential
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_reg   <= 1'b0;
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= req;
            wait_reg  <= !req;
            rdata_reg <= req ? rd_mux : rdata_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            low_ctl_reg  <= LOW_CTL_RST;
            high_ctl_reg <= HIGH_CTL_RST;
            mode_reg     <= MODE_RST;
            mask_reg     <= '0;
            flag_reg     <= '0;
        end else begin
            if (wr_low)  low_ctl_reg  <= AVS_WRITEDATA[CTL_W-1:0];
            if (wr_high) high_ctl_reg <= AVS_WRITEDATA[CTL_W-1:0];
            if (wr_mode) mode_reg     <= AVS_WRITEDATA[2:0];
            if (wr_mask) mask_reg     <= AVS_WRITEDATA[IRQ_W-1:0];
            flag_reg <= flag_next;
        end
    end

    // Power mode and wake come from same-clock logic
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pm_s_reg     <= 2'h0;
            wake_s_reg   <= 1'b0;
            lo_sup_reg   <= 2'h0;
            lo_mon_reg   <= 2'h0;
            hi_sup_reg   <= 2'h0;
            hi_mon_reg   <= 2'h0;
            slow_reg     <= 1'b0;
            mask_out_reg <= 1'b0;
            gate_reg     <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            pm_s_reg     <= POWER_MODE;
            wake_s_reg   <= WAKE_EVENT;
            lo_sup_reg   <= lo_sup_w;
            lo_mon_reg   <= lo_mon_w;
            hi_sup_reg   <= hi_sup_w;
            hi_mon_reg   <= hi_mon_w;
            slow_reg     <= slow_w;
            mask_out_reg <= wk_busy;
            gate_reg     <= gate_w;
            irq_reg      <= |(flag_next & mask_reg);
        end
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign LOW_SUP_STATE   = lo_sup_reg;
    assign LOW_MON_STATE   = lo_mon_reg;
    assign HIGH_SUP_STATE  = hi_sup_reg;
    assign HIGH_MON_STATE  = hi_mon_reg;
    assign SLOW_WAKEUP     = slow_reg;
    assign EXEC_MASK       = mask_out_reg;
    assign SUB_CLK_GATE    = gate_reg;
    assign IRQ             = irq_reg;

    // ========================================
    // Assertions
    a_low_flag_set: assert property (@(posedge CLK) disable iff (SRST)
        wr_low |=> lo_busy) else $error("low delay flag not set"); // see RL17
    a_high_flag_set: assert property (@(posedge CLK) disable iff (SRST)
        wr_high |=> hi_busy) else $error("high delay flag not set"); // see RL17
    a_fast_settle: assert property (@(posedge CLK) disable iff (SRST)
        (wr_low && AVS_WRITEDATA[F_SUP_FULL] == 1'b1 && AVS_WRITEDATA[F_SUP_EN])
        ##1 (!wr_low && !wr_high) [*8] |-> lo_busy) else $error("fast settle too short"); // see RL6
    a_slow_settle: assert property (@(posedge CLK) disable iff (SRST)
        wr_low && AVS_WRITEDATA[F_SUP_EN] && !AVS_WRITEDATA[F_SUP_FULL]
        |-> lo_settle == CNT_W'(SLOW_CYCLES)) else $error("settle load wrong"); // see RL7
    a_wake_mask_len: assert property (@(posedge CLK) disable iff (SRST)
        wake_start && (lo_sup_normal || lo_mon_normal) |-> wake_len == CNT_W'(SLOW_CYCLES))
        else $error("wake mask length wrong"); // see RL1
    a_wake_mask_short: assert property (@(posedge CLK) disable iff (SRST)
        wake_start && !low_ctl_reg[F_SUP_EN] && !low_ctl_reg[F_MON_EN] |-> wake_len == CNT_W'(FAST_CYCLES))
        else $error("wake mask not short"); // see RL2
    a_core_raise: assert property (@(posedge CLK) disable iff (SRST)
        core_raise |=> lo_busy) else $error("core raise without settling"); // see RL8
    a_mask_follow: assert property (@(posedge CLK) disable iff (SRST)
        wake_start |=> ##1 EXEC_MASK) else $error("exec mask not raised"); // see RL2
    a_sub_ungated: assert property (@(posedge CLK) disable iff (SRST)
        mode_reg[F_SUB_DCO] && $past(mode_reg[F_SUB_DCO]) |-> !SUB_CLK_GATE)
        else $error("sub clock gated from oscillator"); // see RL3
    a_slow_wake: assert property (@(posedge CLK) disable iff (SRST)
        lo_sup_normal |=> SLOW_WAKEUP) else $error("slow wakeup not flagged"); // see RL14
    a_low_sup_off: assert property (@(posedge CLK) disable iff (SRST)
        !low_ctl_reg[F_SUP_EN] |=> LOW_SUP_STATE == US_OFF) else $error("low supervisor not off"); // see RL10
    a_mon_auto: assert property (@(posedge CLK) disable iff (SRST)
        deep && high_ctl_reg[F_AUTO] && high_ctl_reg[F_MON_EN] && !high_ctl_reg[F_MON_FULL]
        |=> HIGH_MON_STATE == US_OFF) else $error("high monitor not off"); // see RL13
    a_irq_level: assert property (@(posedge CLK) disable iff (SRST)
        IRQ |-> $past(|(flag_next & mask_reg))) else $error("irq without cause");

    c_low_write: cover property (@(posedge CLK) wr_low ##[1:500] lo_done);
    c_wake: cover property (@(posedge CLK) wake_start ##1 wk_busy);
    c_irq: cover property (@(posedge CLK) !IRQ ##1 IRQ);
    c_deep: cover property (@(posedge CLK) deep && LOW_SUP_STATE == US_NORMAL);
endmodule // ssm_supervisor_mode_ctrl

`default_nettype wire

// ==== tb/tb_ssm_supervisor_mode_ctrl.sv ====
/*
 * Self-checking bench for the supply supervisor mode controller.
 * Assumes ssm_pkg and the design modules are compiled before this file.
 */
`default_nettype none

module tb_ssm_supervisor_mode_ctrl import ssm_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================
    // Signals
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        wake = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [1:0]  pm = 2'h0;
    logic [31:0] rdata;
    logic        wait_req;
    logic [1:0]  lo_sup;
    logic [1:0]  lo_mon;
    logic [1:0]  hi_sup;
    logic [1:0]  hi_mon;
    logic        slow;
    logic        exec_mask;
    logic        gate;
    logic        irq;
    logic [31:0] rv;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t0;
    int          len;
    int          n;
    logic        gate_seen;

    // States 0 off, 1 normal, 2 full
    typedef struct packed {logic [5:0] ctl; logic [1:0] pm; logic [1:0] sup; logic [1:0] mon; logic slow;} ssm_row_type;
    typedef struct {logic [5:0] ctl; logic [2:0] mode; int len; logic gate;} ssm_wake_type;
    ssm_row_type rows [12] = '{
        '{6'h00, 2'd0, 2'd0, 2'd0, 1'b0}, '{6'h09, 2'd0, 2'd1, 2'd1, 1'b1}, '{6'h09, 2'd1, 2'd1, 2'd1, 1'b1},
        '{6'h09, 2'd2, 2'd0, 2'd1, 1'b1}, '{6'h0B, 2'd3, 2'd1, 2'd1, 1'b1}, '{6'h1F, 2'd0, 2'd2, 2'd2, 1'b0},
        '{6'h1F, 2'd2, 2'd2, 2'd2, 1'b0}, '{6'h3F, 2'd3, 2'd1, 2'd1, 1'b0}, '{6'h2B, 2'd2, 2'd0, 2'd0, 1'b1},
        '{6'h25, 2'd3, 2'd0, 2'd0, 1'b0}, '{6'h1D, 2'd2, 2'd0, 2'd2, 1'b0}, '{6'h2D, 2'd0, 2'd2, 2'd1, 1'b0}};
    // Mixed low config kept last: it is the only slow mask the run can afford
    ssm_wake_type wk [3] = '{'{6'h1D, 3'h0, FAST_CYCLES, 1'b1}, '{6'h00, 3'h4, FAST_CYCLES, 1'b0},
                             '{6'h0D, 3'h0, SLOW_CYCLES, 1'b1}};

    ssm_supervisor_mode_ctrl uut (
        .CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .POWER_MODE(pm), .WAKE_EVENT(wake), .LOW_SUP_STATE(lo_sup), .LOW_MON_STATE(lo_mon),
        .HIGH_SUP_STATE(hi_sup), .HIGH_MON_STATE(hi_mon), .SLOW_WAKEUP(slow),
        .EXEC_MASK(exec_mask), .SUB_CLK_GATE(gate), .IRQ(irq)
    );

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // ========================================
    // Tasks
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out(string name);
        bad_count++;
        $display("MISMATCH %s expected done seen timeout", name);
        wrap_up();
    endtask

    task automatic rng(string name, int v, int lo, int hi);
        check(name, 32'(v >= lo && v <= hi), 32'h0000_0001);
    endtask

    // Request held until waitrequest is sampled low; first edge keeps strobes apart
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        if (k >= 50) timed_out("waitrequest");
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(logic [3:0] a, logic [31:0] exp, string name);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rv, exp);
    endtask

    task automatic wait_flags();
        int k;
        k = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000);
            k++;
        end while (rv[1:0] !== 2'b00 && k < 15000);
        if (k >= 15000) timed_out("delay flags");
    endtask

    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 40000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 40000) timed_out("irq");
    endtask

    // ========================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk);
        check("waitrequest in reset", 32'(wait_req), 32'h0000_0001);
        check("readdata in reset", rdata, 32'h0000_0000);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        check("low sup after reset", 32'(lo_sup), 32'h0000_0001);
        check("high mon after reset", 32'(hi_mon), 32'h0000_0001);
        rchk(OFS_LOW_CTL, 32'(LOW_CTL_RST), "low ctl reset");
        rchk(OFS_HIGH_CTL, 32'(HIGH_CTL_RST), "high ctl reset");
        rchk(OFS_MODE, 32'(MODE_RST), "mode reset");
        rchk(OFS_IRQ_MASK, 32'h0000_0000, "mask reset");
        bus(1'b1, 4'h9, 32'hFFFF_FFFF);
        rchk(4'h9, 32'h0000_0000, "unmapped");

        foreach (rows[i]) begin
            bus(1'b1, OFS_LOW_CTL, 32'(rows[i].ctl));
            bus(1'b1, OFS_HIGH_CTL, 32'(rows[i].ctl));
            pm <= rows[i].pm;
            repeat (4) @(posedge clk);
            check("low sup", 32'(lo_sup), 32'(rows[i].sup));
            check("low mon", 32'(lo_mon), 32'(rows[i].mon));
            check("high sup", 32'(hi_sup), 32'(rows[i].sup));
            check("high mon", 32'(hi_mon), 32'(rows[i].mon));
            check("slow wakeup", 32'(slow), 32'(rows[i].slow));
        end

        // ========================================
        // Settling delays, flags and masked interrupt
        pm <= PM_ACTIVE;
        bus(1'b1, OFS_HIGH_CTL, 32'h0000_000D);
        bus(1'b1, OFS_LOW_CTL, 32'h0000_0009);
        t0 = cyc;
        rchk(OFS_STATUS, 32'h0000_0567, "status after write");
        bus(1'b0, OFS_IRQ_FLAG, 32'h0000_0000);
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        wait_irq();
        rng("slow settle", cyc - t0, SLOW_CYCLES - 2, SLOW_CYCLES + 6);
        rchk(OFS_IRQ_FLAG, 32'h0000_0003, "settle flags");
        rchk(OFS_IRQ_FLAG, 32'h0000_0000, "read clears flags");
        rchk(OFS_STATUS, 32'h0000_0567 & 32'hFFFF_FFFC, "flags cleared");
        check("irq after clear", 32'(irq), 32'h0000_0000);
        bus(1'b1, OFS_LOW_CTL, 32'h0000_000D);
        t0 = cyc;
        wait_irq();
        rng("fast settle", cyc - t0, FAST_CYCLES - 2, FAST_CYCLES + 6);
        rchk(OFS_IRQ_FLAG, 32'h0000_0001, "fast flag");

        // ========================================
        // Wakeup mask and sub clock gating
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
        pm <= PM_DEEP2;
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (6) @(posedge clk);
        check("no mask from level two", 32'(exec_mask), 32'h0000_0000);
        foreach (wk[i]) begin
            bus(1'b1, OFS_LOW_CTL, 32'(wk[i].ctl));
            bus(1'b1, OFS_MODE, 32'(wk[i].mode));
            rchk(OFS_MODE, 32'(wk[i].mode), "mode readback");
            wait_flags();
            bus(1'b0, OFS_IRQ_FLAG, 32'h0000_0000);
            pm <= PM_DEEP34;
            wake <= 1'b1;
            @(posedge clk);
            wake <= 1'b0;
            n = 0;
            while (exec_mask !== 1'b1 && n < 10) begin
                @(posedge clk);
                n++;
            end
            if (n >= 10) timed_out("exec mask");
            len = 0;
            gate_seen = 1'b0;
            while (exec_mask === 1'b1 && len < 40000) begin
                gate_seen = gate_seen | gate;
                @(posedge clk);
                len++;
            end
            rng("mask length", len, wk[i].len - 2, wk[i].len + 2);
            check("sub clock gate", 32'(gate_seen), 32'(wk[i].gate));
            pm <= PM_ACTIVE;
            repeat (100) @(posedge clk);
            check("wake irq", 32'(irq), 32'h0000_0001);
        end

        // Core level raise reruns the low settling delay
        bus(1'b1, OFS_MODE, 32'h0000_0002);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        check("core raise delay flag", 32'(rv[0]), 32'h0000_0001);
        // Second reset in mid-run, inside a wake mask
        pm <= PM_DEEP34;
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (4) @(posedge clk);
        check("exec mask before reset", 32'(exec_mask), 32'h0000_0001);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rchk(OFS_LOW_CTL, 32'(LOW_CTL_RST), "low ctl second reset");
        rchk(OFS_IRQ_MASK, 32'h0000_0000, "mask second reset");
        check("exec mask after reset", 32'(exec_mask), 32'h0000_0000);
        wrap_up();
    end
endmodule // tb_ssm_supervisor_mode_ctrl

`default_nettype wire
